// file: msetb_defines.svh
// Purpose: Offsets, field positions, reset values and constants of the execute block
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes:   Definitions only
`ifndef MSETB_DEFINES_SVH
`define MSETB_DEFINES_SVH

// Register byte offsets
`define MSETB_ADR_CTRL    8'h00
`define MSETB_ADR_FLAGS   8'h04
`define MSETB_ADR_STATUS  8'h08
`define MSETB_ADR_FADDR   8'h0c

// Control fields
`define MSETB_CTRL_EN     0
`define MSETB_CTRL_RST    1'h1

// Flag fields
`define MSETB_FLG_N       3
`define MSETB_FLG_Z       2
`define MSETB_FLG_C       1
`define MSETB_FLG_V       0
`define MSETB_FLG_THUMB   4
`define MSETB_FLG_RST     4'h0

// Status fields
`define MSETB_ST_FAULT    0
`define MSETB_ST_BADREG   1

// Program counter relations
`define MSETB_PC_AHEAD    32'h0000_0004
`define MSETB_NEXT_SHORT  32'h0000_0002
`define MSETB_NEXT_LONG   32'h0000_0004

// Register numbers
`define MSETB_LOW_LIMIT   4'h8
`define MSETB_LINK_IDX    4'he

`endif

// file: msetb_pkg.sv
// Purpose: Types shared by the execute block and its transform unit
// Assumes: Decoder presents one operation code per issue
// Notes:   Encoding is local to this block
package msetb_pkg;

  typedef enum logic [3:0] {
    OP_NONE        = 4'h0,
    OP_MUL_LOW     = 4'h1,
    OP_SWAP_WORD   = 4'h2,
    OP_SWAP_HALVES = 4'h3,
    OP_SWAP_SIGNED = 4'h4,
    OP_SEXT_BYTE   = 4'h5,
    OP_ZEXT_BYTE   = 4'h6,
    OP_SEXT_HALF   = 4'h7,
    OP_ZEXT_HALF   = 4'h8,
    OP_AND_TEST    = 4'h9,
    OP_JUMP        = 4'ha,
    OP_JUMP_COND   = 4'hb,
    OP_JUMP_LINK   = 4'hc,
    OP_JUMP_REG    = 4'hd,
    OP_JUMP_LREG   = 4'he
  } msetb_op_t;

endpackage : msetb_pkg

// file: msetb_xu_if.sv
// Purpose: Carrier between execute stage and swap/extend unit
// Assumes: Purely combinational exchange
// Notes:   One source word in, one result word out
`timescale 1ns/10ps
interface msetb_xu_if;
  msetb_pkg::msetb_op_t op;
  logic [31:0]          src;
  logic [31:0]          res;

  modport stage (output op, output src, input res);
  modport unit  (input op, input src, output res);
endinterface : msetb_xu_if

// file: msetb_xfrm_unit.sv
// Purpose: Byte swap and extension results
// Assumes: Source is the single operand of the operation
// Notes:   Other codes give zero
`timescale 1ns/10ps
module msetb_xfrm_unit (
  msetb_xu_if.unit xu
);
  wire [31:0] swap_word;
  wire [31:0] swap_halves;
  wire [31:0] swap_signed;
  wire [31:0] sext_byte;
  wire [31:0] zext_byte;
  wire [31:0] sext_half;
  wire [31:0] zext_half;

  assign swap_word   = {xu.src[7:0], xu.src[15:8], xu.src[23:16], xu.src[31:24]};  // RQ6
  assign swap_halves = {xu.src[23:16], xu.src[31:24], xu.src[7:0], xu.src[15:8]};  // RQ7
  assign swap_signed = {{16{xu.src[7]}}, xu.src[7:0], xu.src[15:8]};               // RQ8
  assign sext_byte   = {{24{xu.src[7]}}, xu.src[7:0]};                             // RQ10
  assign zext_byte   = {24'h00_0000, xu.src[7:0]};                                 // RQ11
  assign sext_half   = {{16{xu.src[15]}}, xu.src[15:0]};                           // RQ12
  assign zext_half   = {16'h0000, xu.src[15:0]};                                   // RQ13

  always_comb begin
    unique case (xu.op)
      msetb_pkg::OP_SWAP_WORD:   xu.res = swap_word;
      msetb_pkg::OP_SWAP_HALVES: xu.res = swap_halves;
      msetb_pkg::OP_SWAP_SIGNED: xu.res = swap_signed;
      msetb_pkg::OP_SEXT_BYTE:   xu.res = sext_byte;
      msetb_pkg::OP_ZEXT_BYTE:   xu.res = zext_byte;
      msetb_pkg::OP_SEXT_HALF:   xu.res = sext_half;
      msetb_pkg::OP_ZEXT_HALF:   xu.res = zext_half;
      default:                   xu.res = 32'h0000_0000;
    endcase
  end
endmodule : msetb_xfrm_unit

// file: msetb_exec.sv
// Purpose: Execute stage for multiply, byte swap, extension, bit test and jumps
// Assumes: Decoder issues one operation per cycle with operands already read
// Notes:   Results appear one cycle after issue; flags held here
//
// How it works
// (RQ1) Multiply two sources, keep only the low 32 product bits as result.
// (RQ2) One multiplier serves signed and unsigned operands alike.
// (RQ3) Multiply sets N and Z from the result, keeps C and V.
// (RQ4) Producer uses only R0 to R7 for multiply operands.
// (RQ5) Producer makes multiply destination equal to its second source.
// (RQ6) Word swap reverses all four bytes.
// (RQ7) Halfword swap exchanges bytes inside each halfword, halfwords stay put.
// (RQ8) Signed swap exchanges low halfword bytes and sign-extends to 32 bits.
// (RQ9) Swaps and extensions keep flags and take only low registers.
// (RQ10) Byte sign extension replicates bit 7 upward.
// (RQ11) Byte zero extension clears the upper 24 bits.
// (RQ12) Halfword sign extension replicates bit 15 upward.
// (RQ13) Halfword zero extension clears the upper 16 bits.
// (RQ14) Bit test ANDs two low registers, sets N and Z, writes nothing.
// (RQ15) Link jumps write the following instruction address into R14.
// (RQ16) The stored return address has bit 0 forced to one.
// (RQ17) Register jumps with target bit 0 clear raise a fatal fault instead.
// (RQ18) Target bit 0 loads the thumb flag and is cleared from the fetch address.
// (RQ19) Offsets span 2 KB, -256 to +254 bytes, and 16 MB by form.
// (RQ20) Only the conditional relative jump evaluates a condition code.
// (RQ21) Producer never names SP or PC as a register jump target.
// (RQ22) Jumps keep all four flags and redirect fetch when taken.
`timescale 1ns/10ps
`include "msetb_defines.svh"
module msetb_exec (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Issue from decoder
  input  wire logic                 issue_valid_i,
  input  wire msetb_pkg::msetb_op_t issue_op_i,
  input  wire logic [3:0]           rd_idx_i,
  input  wire logic [3:0]           rn_idx_i,
  input  wire logic [3:0]           rm_idx_i,
  input  wire logic [31:0]          rn_val_i,
  input  wire logic [31:0]          rm_val_i,
  input  wire logic [31:0]          pc_i,
  input  wire logic [23:0]          offset_i,
  input  wire logic [3:0]           cond_i,
  // Register file write
  output logic                      res_we_o,
  output logic [3:0]                res_idx_o,
  output logic [31:0]               res_data_o,
  output logic                      link_we_o,
  output logic [31:0]               link_data_o,
  // Fetch redirect and fault
  output logic                      jump_o,
  output logic [31:0]               jump_addr_o,
  output logic                      fault_o,
  // Flag state
  output logic [3:0]                flags_o,
  output logic                      thumb_o,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o
);

  msetb_xu_if xu ();

  msetb_xfrm_unit u_xfrm (
    .xu (xu.unit)
  );

  // Register state
  logic        enable_ff;
  logic [3:0]  nzcv_ff;
  logic        thumb_ff;
  logic        st_fault_ff;
  logic        st_badreg_ff;
  logic [31:0] fault_addr_ff;

  // Decode of the issued operation
  wire is_mul     = issue_op_i == msetb_pkg::OP_MUL_LOW;
  wire is_test    = issue_op_i == msetb_pkg::OP_AND_TEST;
  wire is_xfrm    = issue_op_i inside {msetb_pkg::OP_SWAP_WORD, msetb_pkg::OP_SWAP_HALVES,
                                       msetb_pkg::OP_SWAP_SIGNED, msetb_pkg::OP_SEXT_BYTE,
                                       msetb_pkg::OP_ZEXT_BYTE, msetb_pkg::OP_SEXT_HALF,
                                       msetb_pkg::OP_ZEXT_HALF};
  wire is_jrel    = issue_op_i == msetb_pkg::OP_JUMP;
  wire is_jcond   = issue_op_i == msetb_pkg::OP_JUMP_COND;
  wire is_jlink   = issue_op_i == msetb_pkg::OP_JUMP_LINK;
  wire is_jreg    = issue_op_i == msetb_pkg::OP_JUMP_REG;
  wire is_jlreg   = issue_op_i == msetb_pkg::OP_JUMP_LREG;
  wire is_regjump = is_jreg | is_jlreg;

  // Low register checks
  wire rd_low     = rd_idx_i < `MSETB_LOW_LIMIT;
  wire rn_low     = rn_idx_i < `MSETB_LOW_LIMIT;
  wire rm_low     = rm_idx_i < `MSETB_LOW_LIMIT;
  wire mul_ok     = rd_low & rn_low & rm_low & (rd_idx_i == rm_idx_i);  // RQ4 RQ5
  wire xfrm_ok    = rd_low & rm_low;                                    // RQ9
  wire test_ok    = rn_low & rm_low;                                    // RQ14
  wire bad_reg    = (is_mul & ~mul_ok) | (is_xfrm & ~xfrm_ok) | (is_test & ~test_ok);

  wire fire       = issue_valid_i & enable_ff & (issue_op_i != msetb_pkg::OP_NONE);
  wire fire_ok    = fire & ~bad_reg;

  // Arithmetic results
  wire [63:0] mul_full = {32'h0000_0000, rn_val_i} * {32'h0000_0000, rm_val_i};  // RQ2
  wire [31:0] mul_res  = mul_full[31:0];                                          // RQ1
  wire [31:0] test_res = rn_val_i & rm_val_i;                                     // RQ14

  assign xu.op  = issue_op_i;
  assign xu.src = rm_val_i;

  wire [31:0] data_res = is_mul ? mul_res : xu.res;
  wire [31:0] nz_src   = is_mul ? mul_res : test_res;
  wire        nz_upd   = fire_ok & (is_mul | is_test);                            // RQ3 RQ14
  wire        rf_write = fire_ok & (is_mul | is_xfrm);                            // RQ14

  // Relative offsets by form
  wire [31:0] off_short = {{20{offset_i[10]}}, offset_i[10:0], 1'b0};  // RQ19
  wire [31:0] off_cond  = {{23{offset_i[7]}}, offset_i[7:0], 1'b0};    // RQ19
  wire [31:0] off_link  = {{7{offset_i[23]}}, offset_i[23:0], 1'b0};   // RQ19
  wire [31:0] pc_read   = pc_i + `MSETB_PC_AHEAD;

  logic [31:0] rel_off;
  always_comb begin
    rel_off = off_short;
    if (is_jcond) begin
      rel_off = off_cond;
    end else if (is_jlink) begin
      rel_off = off_link;
    end
  end

  // Condition evaluation
  wire f_n = nzcv_ff[`MSETB_FLG_N];
  wire f_z = nzcv_ff[`MSETB_FLG_Z];
  wire f_c = nzcv_ff[`MSETB_FLG_C];
  wire f_v = nzcv_ff[`MSETB_FLG_V];

  logic cond_pass;
  always_comb begin
    unique case (cond_i)
      4'h0: cond_pass = f_z;
      4'h1: cond_pass = ~f_z;
      4'h2: cond_pass = f_c;
      4'h3: cond_pass = ~f_c;
      4'h4: cond_pass = f_n;
      4'h5: cond_pass = ~f_n;
      4'h6: cond_pass = f_v;
      4'h7: cond_pass = ~f_v;
      4'h8: cond_pass = f_c & ~f_z;
      4'h9: cond_pass = ~f_c | f_z;
      4'ha: cond_pass = f_n == f_v;
      4'hb: cond_pass = f_n != f_v;
      4'hc: cond_pass = ~f_z & (f_n == f_v);
      4'hd: cond_pass = f_z | (f_n != f_v);
      4'he: cond_pass = 1'b1;
      4'hf: cond_pass = 1'b0;
    endcase
  end

  // Jump decisions
  wire        rel_take  = is_jrel | is_jlink | (is_jcond & cond_pass);            // RQ20
  wire        reg_bad   = is_regjump & ~rm_val_i[0];                              // RQ17
  wire        jump_take = fire_ok & (rel_take | (is_regjump & rm_val_i[0]));      // RQ22
  wire        fault_now = fire_ok & reg_bad;                                      // RQ17
  wire [31:0] reg_tgt   = {rm_val_i[31:1], 1'b0};                                 // RQ18
  wire [31:0] rel_tgt   = pc_read + rel_off;
  wire [31:0] jump_tgt  = is_regjump ? reg_tgt : rel_tgt;

  // Return address of the following instruction
  wire [31:0] next_pc   = pc_i + (is_jlink ? `MSETB_NEXT_LONG : `MSETB_NEXT_SHORT);  // RQ15
  wire [31:0] ret_addr  = {next_pc[31:1], 1'b1};                                     // RQ16
  wire        link_wr   = fire_ok & (is_jlink | (is_jlreg & rm_val_i[0]));           // RQ15

  // Bus decode
  wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  wire        wr_ctrl   = bus_wr & (wb_adr_i == `MSETB_ADR_CTRL);
  wire        wr_flags  = bus_wr & (wb_adr_i == `MSETB_ADR_FLAGS);
  wire        wr_status = bus_wr & (wb_adr_i == `MSETB_ADR_STATUS);

  logic [31:0] rd_mux;
  always_comb begin
    unique case (wb_adr_i)
      `MSETB_ADR_CTRL:   rd_mux = {31'h0000_0000, enable_ff};
      `MSETB_ADR_FLAGS:  rd_mux = {27'h000_0000, thumb_ff, nzcv_ff};
      `MSETB_ADR_STATUS: rd_mux = {30'h0000_0000, st_badreg_ff, st_fault_ff};
      `MSETB_ADR_FADDR:  rd_mux = fault_addr_ff;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Flag next value: execution wins over a bus write
  logic [3:0] nxt_nzcv;
  always_comb begin
    nxt_nzcv = nzcv_ff;
    if (wr_flags) begin
      nxt_nzcv = wb_dat_i[3:0];
    end
    if (nz_upd) begin
      nxt_nzcv[`MSETB_FLG_N] = nz_src[31];                // RQ3
      nxt_nzcv[`MSETB_FLG_Z] = nz_src == 32'h0000_0000;   // RQ3
    end
  end

  // Sticky status: set wins over write-one-to-clear
  wire nxt_st_fault  = fault_now | (st_fault_ff & ~(wr_status & wb_dat_i[`MSETB_ST_FAULT]));
  wire nxt_st_badreg = (fire & bad_reg) | (st_badreg_ff & ~(wr_status & wb_dat_i[`MSETB_ST_BADREG]));

  // Control and status registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_ff    <= `MSETB_CTRL_RST;
      nzcv_ff      <= `MSETB_FLG_RST;
      st_fault_ff  <= 1'b0;
      st_badreg_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        enable_ff <= wb_dat_i[`MSETB_CTRL_EN];
      end
      nzcv_ff      <= nxt_nzcv;
      st_fault_ff  <= nxt_st_fault;
      st_badreg_ff <= nxt_st_badreg;
    end
  end

  // Thumb flag and fault address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thumb_ff      <= 1'b1;
      fault_addr_ff <= 32'h0000_0000;
    end else begin
      if (wr_flags) begin
        thumb_ff <= wb_dat_i[`MSETB_FLG_THUMB];
      end
      if (fire_ok & is_regjump) begin
        thumb_ff <= rm_val_i[0];  // RQ18
      end
      if (fault_now) begin
        fault_addr_ff <= pc_i;
      end
    end
  end

  // Register file write port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_we_o   <= 1'b0;
      res_idx_o  <= 4'h0;
      res_data_o <= 32'h0000_0000;
    end else begin
      res_we_o <= rf_write;  // RQ9 RQ14
      if (rf_write) begin
        res_idx_o  <= rd_idx_i;
        res_data_o <= data_res;
      end
    end
  end

  // Link write port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_we_o   <= 1'b0;
      link_data_o <= 32'h0000_0000;
    end else begin
      link_we_o <= link_wr;  // RQ15
      if (link_wr) begin
        link_data_o <= ret_addr;  // RQ16
      end
    end
  end

  // Fetch redirect and fault pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jump_o      <= 1'b0;
      jump_addr_o <= 32'h0000_0000;
      fault_o     <= 1'b0;
    end else begin
      jump_o  <= jump_take;   // RQ22
      fault_o <= fault_now;   // RQ17
      if (jump_take) begin
        jump_addr_o <= jump_tgt;
      end
    end
  end

  // Flag outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_o <= `MSETB_FLG_RST;
      thumb_o <= 1'b1;
    end else begin
      flags_o <= nxt_nzcv;
      thumb_o <= (fire_ok & is_regjump) ? rm_val_i[0] : (wr_flags ? wb_dat_i[`MSETB_FLG_THUMB] : thumb_ff);
    end
  end

  // Bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : msetb_exec

// file: msetb_exec_properties.sv
// Purpose: Port assertions for the execute block
// Assumes: Sees only the top ports
// Notes: Bound after the module
`timescale 1ns/10ps
module msetb_exec_chk (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  // Issue
  input wire logic                 issue_valid_i,
  input wire msetb_pkg::msetb_op_t issue_op_i,
  input wire logic [31:0]          rn_val_i,
  input wire logic [31:0]          rm_val_i,
  input wire logic [31:0]          pc_i,
  input wire logic [23:0]          offset_i,
  input wire logic [3:0]           cond_i,
  // Results
  input wire logic                 res_we_o,
  input wire logic [31:0]          res_data_o,
  input wire logic                 link_we_o,
  input wire logic [31:0]          link_data_o,
  input wire logic                 jump_o,
  input wire logic [31:0]          jump_addr_o,
  input wire logic [3:0]           flags_o,
  input wire logic                 thumb_o,
  // Bus
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i
);
  logic                 v_ff;
  logic                 bw_ff;
  msetb_pkg::msetb_op_t op_ff;
  logic [31:0]          a_ff;
  logic [31:0]          b_ff;
  logic [31:0]          pc_ff;
  logic [23:0]          off_ff;
  logic [3:0]           cnd_ff;
  logic [3:0]           fl_ff;
  always_ff @(posedge clk_i) begin
    v_ff <= issue_valid_i;
    bw_ff <= wb_cyc_i & wb_stb_i & wb_we_i;
    op_ff <= issue_op_i;
    a_ff <= rn_val_i;
    b_ff <= rm_val_i;
    pc_ff <= pc_i;
    off_ff <= offset_i;
    cnd_ff <= cond_i;
    fl_ff <= flags_o;
  end
  wire        is_x = op_ff >= msetb_pkg::OP_SWAP_WORD && op_ff <= msetb_pkg::OP_ZEXT_HALF;
  wire        is_mul = op_ff == msetb_pkg::OP_MUL_LOW;
  wire        is_rel = op_ff >= msetb_pkg::OP_JUMP && op_ff <= msetb_pkg::OP_JUMP_LINK;
  wire        keep = v_ff && !bw_ff;
  wire [31:0] t = a_ff & b_ff;
  function automatic logic [31:0] xf(input msetb_pkg::msetb_op_t o, input logic [31:0] s);
    case (o)
      msetb_pkg::OP_SWAP_WORD: xf = {s[7:0], s[15:8], s[23:16], s[31:24]};
      msetb_pkg::OP_SWAP_HALVES: xf = {s[23:16], s[31:24], s[7:0], s[15:8]};
      msetb_pkg::OP_SWAP_SIGNED: xf = {{16{s[7]}}, s[7:0], s[15:8]};
      msetb_pkg::OP_SEXT_BYTE: xf = {{24{s[7]}}, s[7:0]};
      msetb_pkg::OP_ZEXT_BYTE: xf = {24'h0, s[7:0]};
      msetb_pkg::OP_SEXT_HALF: xf = {{16{s[15]}}, s[15:0]};
      default: xf = {16'h0, s[15:0]};
    endcase
  endfunction : xf
  function automatic logic [31:0] rel(input msetb_pkg::msetb_op_t o, input logic [31:0] p,
                                      input logic [23:0] f);
    logic [31:0] d;
    if (o == msetb_pkg::OP_JUMP) d = {{21{f[10]}}, f[10:0]};
    else if (o == msetb_pkg::OP_JUMP_COND) d = {{24{f[7]}}, f[7:0]};
    else d = {{8{f[23]}}, f};
    rel = p + 32'h4 + {d[30:0], 1'b0};
  endfunction : rel
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rjump;
    v_ff && (op_ff == msetb_pkg::OP_JUMP_REG || op_ff == msetb_pkg::OP_JUMP_LREG);
  endsequence
  chk_mul_result: assert property (res_we_o && is_mul |-> res_data_o == a_ff * b_ff)
    else $error("multiply result wrong");
  chk_mul_flags: assert property (res_we_o && is_mul && !bw_ff |->
    flags_o == {res_data_o[31], res_data_o == 32'h0, fl_ff[1:0]}) else $error("multiply flags wrong");
  chk_xfrm_data: assert property (res_we_o && is_x |-> res_data_o == xf(op_ff, b_ff))
    else $error("swap or extend result wrong");
  chk_xfrm_flags: assert property (keep && is_x |-> flags_o == fl_ff)
    else $error("swap or extend touched flags");
  chk_test_result: assert property (keep && op_ff == msetb_pkg::OP_AND_TEST |-> !res_we_o &&
    flags_o[1:0] == fl_ff[1:0] && (flags_o[3:2] == fl_ff[3:2] || flags_o[3:2] == {t[31], t == 32'h0}))
    else $error("bit test wrong");
  chk_link_value: assert property (link_we_o |-> link_data_o ==
    ((pc_ff + (op_ff == msetb_pkg::OP_JUMP_LINK ? 32'h4 : 32'h2)) | 32'h1)) else $error("link value wrong");
  chk_fault_block: assert property (s_rjump ##0 !b_ff[0] |-> !jump_o && !link_we_o)
    else $error("jump taken on even target");
  chk_reg_target: assert property (s_rjump ##0 jump_o |-> jump_addr_o == {b_ff[31:1], 1'b0} && thumb_o)
    else $error("register jump target wrong");
  chk_rel_target: assert property (jump_o && is_rel |-> jump_addr_o == rel(op_ff, pc_ff, off_ff))
    else $error("relative target wrong");
  chk_never_cond: assert property (v_ff && op_ff == msetb_pkg::OP_JUMP_COND && cnd_ff == 4'hf |-> !jump_o)
    else $error("never condition jumped");
  chk_jump_flags: assert property (keep && op_ff >= msetb_pkg::OP_JUMP |-> flags_o == fl_ff)
    else $error("jump touched flags");
endmodule : msetb_exec_chk
bind msetb_exec msetb_exec_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .issue_valid_i(issue_valid_i),
  .issue_op_i(issue_op_i), .rn_val_i(rn_val_i), .rm_val_i(rm_val_i), .pc_i(pc_i), .offset_i(offset_i),
  .cond_i(cond_i), .res_we_o(res_we_o), .res_data_o(res_data_o), .link_we_o(link_we_o),
  .link_data_o(link_data_o), .jump_o(jump_o), .jump_addr_o(jump_addr_o), .flags_o(flags_o),
  .thumb_o(thumb_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i));

// file: msetb_rf_model.sv
// Purpose: Register file beside the execute block
// Assumes: Bench preloads operands directly
// Notes: Reads are combinational
`timescale 1ns/10ps
module msetb_rf_model (
  // Clock
  input wire logic        clk_i,
  // Operand reads
  input wire logic [3:0]  rn_idx_i,
  input wire logic [3:0]  rm_idx_i,
  output logic [31:0]     rn_val_o,
  output logic [31:0]     rm_val_o,
  // Writes
  input wire logic        we_i,
  input wire logic [3:0]  idx_i,
  input wire logic [31:0] dat_i,
  input wire logic        link_we_i,
  input wire logic [31:0] link_dat_i
);
  logic [31:0] regs [16];
  assign rn_val_o = regs[rn_idx_i];
  assign rm_val_o = regs[rm_idx_i];
  always @(posedge clk_i) begin
    if (we_i) regs[idx_i] <= dat_i;
    if (link_we_i) regs[4'he] <= link_dat_i;
  end
endmodule : msetb_rf_model

// file: testbench.sv
// Purpose: Self-checking bench for the execute block
// Assumes: Operands come from the register file model
// Notes: Bus waits are bounded
`timescale 1ns/10ps
module testbench;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 iv = 1'b0;
  logic                 cyc = 1'b0;
  logic                 stb = 1'b0;
  logic                 we = 1'b0;
  msetb_pkg::msetb_op_t op = msetb_pkg::OP_NONE;
  logic [11:0]          ix = 12'h0;
  logic [31:0]          pc = 32'h0;
  logic [23:0]          off = 24'h0;
  logic [3:0]           cnd = 4'h0;
  logic [7:0]           adr = 8'h0;
  logic [31:0]          wd = 32'h0;
  logic [31:0]          rdat, rn_v, rm_v, res_d, lnk_d, jad, bdo;
  logic [3:0]           ridx, fl, st;
  logic                 res_we, lnk_we, jmp, flt, thb, ack;
  logic [31:0]          xexp [7] = '{32'hf680_3412, 32'h3412_f680, 32'hffff_f680, 32'hffff_fff6,
                                     32'h0000_00f6, 32'hffff_80f6, 32'h0000_80f6};
  logic [15:0]          cpass [2] = '{16'h55a6, 16'h6a65};
  int                   n_errors = 0;
  int                   n_compared = 0;
  msetb_exec dut (.clk_i(clk_i), .rst_i(rst_i), .issue_valid_i(iv), .issue_op_i(op),
    .rd_idx_i(ix[11:8]), .rn_idx_i(ix[7:4]), .rm_idx_i(ix[3:0]), .rn_val_i(rn_v),
    .rm_val_i(rm_v), .pc_i(pc), .offset_i(off), .cond_i(cnd), .res_we_o(res_we),
    .res_idx_o(ridx), .res_data_o(res_d), .link_we_o(lnk_we), .link_data_o(lnk_d),
    .jump_o(jmp), .jump_addr_o(jad), .fault_o(flt), .flags_o(fl), .thumb_o(thb),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(bdo), .wb_ack_o(ack));
  msetb_rf_model u_rf (.clk_i(clk_i), .rn_idx_i(ix[7:4]), .rm_idx_i(ix[3:0]), .rn_val_o(rn_v),
    .rm_val_o(rm_v), .we_i(res_we), .idx_i(ridx), .dat_i(res_d), .link_we_i(lnk_we),
    .link_dat_i(lnk_d));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rdat = bdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(rdat, e);
  endtask : rdc
  task automatic run(input msetb_pkg::msetb_op_t o, input logic [3:0] es, input logic [31:0] p,
      input logic [23:0] f, input logic [3:0] c, input logic [11:0] x = 12'h0,
      input logic [31:0] b = 32'h0, input logic [31:0] a = 32'h0);
    @(posedge clk_i);
    iv <= 1'b1;
    op <= o;
    ix <= x;
    pc <= p;
    off <= f;
    cnd <= c;
    #1;
    u_rf.regs[x[7:4]] = a;
    u_rf.regs[x[3:0]] = b;
    @(posedge clk_i);
    iv <= 1'b0;
    #1;
    st = {res_we, lnk_we, jmp, flt};
    cmp(32'(st), 32'(es));
  endtask : run
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h00, 32'h1);
    rdc(8'h04, 32'h10);
    rdc(8'h20, 32'h0);
    wb(1'b1, 8'h04, 32'h13);
    run(msetb_pkg::OP_MUL_LOW, 4'h8, 32'h0, 24'h0, 4'hf, 12'h101, 32'hffff_ffff, 32'h5);
    cmp(res_d, 32'hffff_fffb);
    cmp(32'(ridx), 32'h1);
    cmp(32'(fl), 32'hb);
    run(msetb_pkg::OP_MUL_LOW, 4'h8, 32'h0, 24'h0, 4'h0, 12'h101, 32'h3_0007, 32'h1_0003);
    cmp(res_d, 32'h0010_0015);
    cmp(32'(fl), 32'h3);
    run(msetb_pkg::OP_MUL_LOW, 4'h8, 32'h0, 24'h0, 4'h0, 12'h101, 32'h1_0000, 32'h1_0000);
    cmp(res_d, 32'h0);
    cmp(32'(fl), 32'h7);
    for (int k = 0; k < 7; k++) begin
      run(msetb_pkg::msetb_op_t'(4'(k + 2)), 4'h8, 32'h0, 24'h0, 4'h0, 12'h200, 32'h1234_80f6);
      cmp(res_d, xexp[k]);
      cmp(32'(fl), 32'h7);
    end
    run(msetb_pkg::OP_SEXT_BYTE, 4'h0, 32'h0, 24'h0, 4'h0, 12'h800);
    rdc(8'h08, 32'h2);
    wb(1'b1, 8'h08, 32'h2);
    run(msetb_pkg::OP_AND_TEST, 4'h0, 32'h0, 24'h0, 4'h0, 12'h034, 32'h8000_00f0, 32'h8000_0001);
    cmp(32'(fl), 32'hb);
    run(msetb_pkg::OP_AND_TEST, 4'h0, 32'h0, 24'h0, 4'h0, 12'h034, 32'h0f00, 32'h8000_00ff);
    cmp(32'(fl), 32'h7);
    run(msetb_pkg::OP_JUMP, 4'h2, 32'h1000, 24'h5a_b400, 4'h0);
    cmp(jad, 32'h804);
    run(msetb_pkg::OP_JUMP, 4'h2, 32'h1000, 24'h3ff, 4'h0);
    cmp(jad, 32'h1802);
    run(msetb_pkg::OP_JUMP_COND, 4'h2, 32'h1000, 24'h80, 4'h0);
    cmp(jad, 32'hf04);
    run(msetb_pkg::OP_JUMP_COND, 4'h0, 32'h1000, 24'h7f, 4'h1);
    run(msetb_pkg::OP_JUMP_COND, 4'h2, 32'h1000, 24'h7f, 4'he);
    cmp(jad, 32'h1102);
    run(msetb_pkg::OP_JUMP_COND, 4'h0, 32'h1000, 24'h7f, 4'hf);
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, 8'h04, m ? 32'h17 : 32'h12);
      for (int k = 0; k < 16; k++) begin
        run(msetb_pkg::OP_JUMP_COND, {2'h0, cpass[m][k], 1'h0}, 32'h1000, 24'h7f, 4'(k));
      end
    end
    run(msetb_pkg::OP_JUMP_LINK, 4'h6, 32'h2000, 24'h80_0000, 4'h0);
    cmp(jad, 32'hff00_2004);
    cmp(lnk_d, 32'h2005);
    run(msetb_pkg::OP_JUMP_LREG, 4'h6, 32'h200, 24'h0, 4'h0, 12'h005, 32'h101);
    cmp(jad, 32'h100);
    cmp(lnk_d, 32'h203);
    cmp(32'(fl), 32'h7);
    run(msetb_pkg::OP_JUMP_REG, 4'h1, 32'h400, 24'h0, 4'h0, 12'h005, 32'h300);
    cmp(u_rf.regs[14], 32'h203);
    cmp(32'(thb), 32'h0);
    rdc(8'h08, 32'h1);
    rdc(8'h0c, 32'h400);
    run(msetb_pkg::OP_JUMP_REG, 4'h2, 32'h400, 24'h0, 4'h0, 12'h005, 32'h4001);
    cmp(jad, 32'h4000);
    cmp(32'(thb), 32'h1);
    wb(1'b1, 8'h00, 32'h0);
    run(msetb_pkg::OP_MUL_LOW, 4'h0, 32'h0, 24'h0, 4'h0, 12'h101, 32'h5, 32'h5);
    wb(1'b1, 8'h00, 32'h1);
    end_sim();
  end
endmodule : testbench
